//--- core/odsc_pkg.sv
// Constants for the octal DAC serial control block.
// Assumes a single 100 MHz system clock; all pins except clear_n are sampled by that clock.
package odsc_pkg;
  // Frame geometry
  localparam int unsigned FRAME_BITS  = 24;
  localparam int unsigned CNT_W       = 5;
  localparam logic [4:0]  FRAME_LAST  = 5'h18;
  localparam int unsigned NUM_CH      = 8;
  localparam int unsigned DATA_W      = 12;
  // Field positions inside the 24-bit word
  localparam int unsigned POS_PREFIX_HI = 23;
  localparam int unsigned POS_PREFIX_LO = 22;
  localparam int unsigned POS_LD_HI     = 21;
  localparam int unsigned POS_LD_LO     = 20;
  localparam int unsigned POS_PICK_HI   = 19;
  localparam int unsigned POS_PICK_LO   = 17;
  localparam int unsigned POS_PD        = 16;
  localparam int unsigned POS_DATA_HI   = 15;
  localparam int unsigned POS_DATA_LO   = 4;
  localparam int unsigned POS_PDM_HI    = 11;
  localparam int unsigned POS_PDM_LO    = 10;
  // Load control codes
  localparam logic [1:0] LD_BUF_ONLY  = 2'h0;
  localparam logic [1:0] LD_BUF_DAC   = 2'h1;
  localparam logic [1:0] LD_BUF_ALL   = 2'h2;
  localparam logic [1:0] LD_GROUP     = 2'h3;
  localparam logic [1:0] PREFIX_OK    = 2'h0;
  // Power-down modes
  localparam logic [1:0] PDM_HIZ      = 2'h0;
  localparam logic [1:0] PDM_1K       = 2'h1;
  localparam logic [1:0] PDM_100K     = 2'h2;
  // Register map (byte addresses)
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_LAST    = 8'h08;
  localparam logic [2:0] PAGE_DAC     = 3'h1;
  localparam logic [2:0] PAGE_BUF     = 3'h2;
  localparam logic [31:0] CTRL_RST    = 32'h00000001;
  // Status bit positions
  localparam int unsigned ST_COMMIT   = 0;
  localparam int unsigned ST_ABORT    = 1;
  localparam int unsigned ST_REJECT   = 2;
  localparam int unsigned ST_PD_LO    = 8;
  localparam int unsigned ST_SLEEP    = 16;
  localparam int unsigned ST_CHAIN    = 17;
  localparam int unsigned ST_FMT      = 18;
  // Bus responses
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  // Frame receiver states
  typedef enum logic [1:0] {ODSC_IDLE, ODSC_SHIFT, ODSC_FULL} odsc_state_t;
endpackage

//--- core/odsc_top.sv
// Octal 12-bit DAC serial control: frame receiver, decoder, channel registers, AXI4-Lite view.
// Assumes serial pins come from a foreign clock and are oversampled by clk (100 MHz).
`timescale 1ns/1ps
module odsc_top #(
  parameter int unsigned NUM_CH = odsc_pkg::NUM_CH,
  parameter int unsigned DATA_W = odsc_pkg::DATA_W
) (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  // Device pins
  input  wire logic                       frame_sync_n,
  input  wire logic                       serial_clk,
  input  wire logic                       serial_in,
  input  wire logic                       chain_enable,
  input  wire logic                       sleep_pin_n,
  input  wire logic                       clear_n,
  input  wire logic                       reset_level_select,
  output logic                            serial_out,
  output logic                            serial_out_oe_n,
  // Analog-side view
  output logic [NUM_CH*DATA_W-1:0]        dac_code,
  output logic [NUM_CH-1:0]               ch_power_down,
  output logic [2*NUM_CH-1:0]             ch_pd_mode,
  // AXI4-Lite slave
  input  wire logic [odsc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [odsc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready
);

  // Clear pin acts as an asynchronous reset, same as power-on
  logic rst_all;
  assign rst_all = sys_rst | ~clear_n;

  // Two-stage synchronisers plus one delay stage for edge detection
  logic [2:0] sync_sh_q;
  logic [2:0] sclk_sh_q;
  logic [1:0] serial_in_sh_q;
  logic [1:0] chain_sh_q;
  logic [1:0] sleep_sh_q;
  logic [1:0] rsel_sh_q;
  always_ff @(posedge clk or posedge rst_all) begin
    if (rst_all) begin
      sync_sh_q  <= 3'h7;
      sclk_sh_q  <= 3'h7;
      serial_in_sh_q  <= 2'h0;
      chain_sh_q <= 2'h0;
      sleep_sh_q <= 2'h3;
      rsel_sh_q  <= 2'h0;
    end else begin
      sync_sh_q  <= {sync_sh_q[1:0], frame_sync_n};
      sclk_sh_q  <= {sclk_sh_q[1:0], serial_clk};
      serial_in_sh_q  <= {serial_in_sh_q[0], serial_in};
      chain_sh_q <= {chain_sh_q[0], chain_enable};
      sleep_sh_q <= {sleep_sh_q[0], sleep_pin_n};
      rsel_sh_q  <= {rsel_sh_q[0], reset_level_select};
    end
  end

  logic sync_s, sync_fall, sync_rise, sclk_fall, serial_in_s, chain_s, sleep_s, fmt_s;
  assign sync_s    = sync_sh_q[1];
  assign sync_fall = sync_sh_q[2] & ~sync_sh_q[1];
  assign sync_rise = ~sync_sh_q[2] & sync_sh_q[1];
  assign sclk_fall = sclk_sh_q[2] & ~sclk_sh_q[1];
  assign serial_in_s    = serial_in_sh_q[1];
  assign chain_s   = chain_sh_q[1];
  assign sleep_s   = sleep_sh_q[1];
  assign fmt_s     = rsel_sh_q[1];

  // Frame receiver
  odsc_pkg::odsc_state_t          state_q;
  logic [odsc_pkg::CNT_W-1:0]     cnt_q;
  logic [odsc_pkg::FRAME_BITS-1:0] shift_q;
  logic                           shift_en;
  logic                           full;
  logic [31:0]                    ctrl_q;
  assign full     = (cnt_q == odsc_pkg::FRAME_LAST);
  // Past 24 bits only chain mode keeps shifting
  assign shift_en = ~sync_s & sclk_fall & (state_q != odsc_pkg::ODSC_IDLE)
                    & (~full | chain_s);

  always_ff @(posedge clk or posedge rst_all) begin
    if (rst_all) begin
      state_q <= odsc_pkg::ODSC_IDLE;
      cnt_q   <= '0;
      shift_q <= '0;
    end else begin
      if (shift_en) begin
        shift_q <= {shift_q[odsc_pkg::FRAME_BITS-2:0], serial_in_s};
      end
      case (state_q)
        odsc_pkg::ODSC_IDLE: begin
          // A fresh frame needs sync to have gone high and low again
          if (sync_fall) begin
            state_q <= odsc_pkg::ODSC_SHIFT;
            cnt_q   <= '0;
          end
        end
        odsc_pkg::ODSC_SHIFT: begin
          if (sync_rise) begin
            state_q <= odsc_pkg::ODSC_IDLE;
          end else if (shift_en) begin
            cnt_q <= cnt_q + 5'h1;
            if (cnt_q == odsc_pkg::FRAME_LAST - 5'h1) begin
              state_q <= odsc_pkg::ODSC_FULL;
            end
          end
        end
        odsc_pkg::ODSC_FULL: begin
          if (sync_rise) begin
            state_q <= odsc_pkg::ODSC_IDLE;
          end
        end
        default: state_q <= odsc_pkg::ODSC_IDLE;
      endcase
    end
  end

  // Commit or abort decision on the sync rising edge
  logic commit, abort_ev, reject_ev;
  logic [1:0]        prefix, ld;
  logic [2:0]        pick;
  logic              pd_bit;
  logic [DATA_W-1:0] data;
  logic [1:0]        pdm;
  assign prefix    = shift_q[odsc_pkg::POS_PREFIX_HI:odsc_pkg::POS_PREFIX_LO];
  assign ld        = shift_q[odsc_pkg::POS_LD_HI:odsc_pkg::POS_LD_LO];
  assign pick      = shift_q[odsc_pkg::POS_PICK_HI:odsc_pkg::POS_PICK_LO];
  assign pd_bit    = shift_q[odsc_pkg::POS_PD];
  assign data      = shift_q[odsc_pkg::POS_DATA_HI:odsc_pkg::POS_DATA_LO];
  assign pdm       = shift_q[odsc_pkg::POS_PDM_HI:odsc_pkg::POS_PDM_LO];
  // Software may block commits through the control register
  assign commit    = sync_rise & (state_q == odsc_pkg::ODSC_FULL) & ctrl_q[0]
                     & (prefix == odsc_pkg::PREFIX_OK);
  assign abort_ev  = sync_rise & (state_q == odsc_pkg::ODSC_SHIFT);
  assign reject_ev = sync_rise & (state_q == odsc_pkg::ODSC_FULL) & ~commit;

  // Channel masks: group load ends at pick[1:0]*2+1, group power-down at pick+1
  logic [NUM_CH-1:0] sel_mask, grp_load_mask, grp_pd_mask;
  always_comb begin
    sel_mask      = '0;
    grp_load_mask = '0;
    grp_pd_mask   = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      sel_mask[i]      = (pick == i[2:0]);
      grp_load_mask[i] = (i[2:0] <= {pick[1:0], 1'b1});
      grp_pd_mask[i]   = (i[3:0] <= {1'b0, pick} + 4'h1);
    end
  end

  // Next values of buffers, DAC registers and power-down state
  logic [NUM_CH-1:0][DATA_W-1:0] buf_q, buf_d, dac_q, dac_d;
  logic [NUM_CH-1:0]             pd_q, pd_d;
  logic [NUM_CH-1:0][1:0]        pdm_q, pdm_d;
  always_comb begin
    buf_d = buf_q;
    dac_d = dac_q;
    pd_d  = pd_q;
    pdm_d = pdm_q;
    if (commit) begin
      if (pd_bit) begin
        // Power-down scope follows the low load bit
        for (int i = 0; i < NUM_CH; i++) begin
          if (ld[0] ? grp_pd_mask[i] : sel_mask[i]) begin
            pd_d[i]  = 1'b1;
            pdm_d[i] = pdm;
          end
        end
      end else begin
        for (int i = 0; i < NUM_CH; i++) begin
          case (ld)
            odsc_pkg::LD_BUF_ONLY: begin
              if (sel_mask[i]) buf_d[i] = data;
            end
            odsc_pkg::LD_BUF_DAC: begin
              if (sel_mask[i]) begin
                buf_d[i] = data;
                dac_d[i] = data;
                pd_d[i]  = 1'b0;
              end
            end
            odsc_pkg::LD_BUF_ALL: begin
              if (sel_mask[i]) buf_d[i] = data;
              dac_d[i] = sel_mask[i] ? data : buf_q[i];
              pd_d[i]  = 1'b0;
            end
            odsc_pkg::LD_GROUP: begin
              if (grp_load_mask[i]) begin
                if (pick[2]) buf_d[i] = data;
                dac_d[i] = pick[2] ? data : buf_q[i];
                pd_d[i]  = 1'b0;
              end
            end
            default: buf_d[i] = buf_q[i];
          endcase
        end
      end
    end
  end

  // Raw codes reset to zero; the output stage maps zero to the reset level
  always_ff @(posedge clk or posedge rst_all) begin
    if (rst_all) begin
      buf_q <= '0;
      dac_q <= '0;
    end else begin
      buf_q <= buf_d;
      dac_q <= dac_d;
    end
  end

  // Power-down state per channel
  always_ff @(posedge clk or posedge rst_all) begin
    if (rst_all) begin
      pd_q  <= '0;
      pdm_q <= '0;
    end else begin
      pd_q  <= pd_d;
      pdm_q <= pdm_d;
    end
  end

  // Output stage: format flip and sleep override, stored state untouched
  logic [NUM_CH*DATA_W-1:0] dac_code_q;
  logic [NUM_CH-1:0]        ch_pd_q;
  logic [2*NUM_CH-1:0]      ch_pdm_q;
  always_ff @(posedge clk or posedge rst_all) begin
    if (rst_all) begin
      dac_code_q <= '0;
      ch_pd_q    <= '0;
      ch_pdm_q   <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        dac_code_q[i*DATA_W +: DATA_W] <= dac_q[i] ^ {fmt_s, {(DATA_W-1){1'b0}}};
        ch_pd_q[i]      <= pd_q[i] | ~sleep_s;
        ch_pdm_q[i*2 +: 2] <= sleep_s ? pdm_q[i] : odsc_pkg::PDM_HIZ;
      end
    end
  end
  assign dac_code      = dac_code_q;
  assign ch_power_down = ch_pd_q;
  assign ch_pd_mode    = ch_pdm_q;

  // Serial out carries the bit shifted in 24 clocks earlier
  logic so_q, so_oe_n_q;
  always_ff @(posedge clk or posedge rst_all) begin
    if (rst_all) begin
      so_q      <= 1'b0;
      so_oe_n_q <= 1'b1;
    end else begin
      so_q      <= shift_q[odsc_pkg::FRAME_BITS-1];
      so_oe_n_q <= sync_s | ~chain_s;
    end
  end
  assign serial_out      = so_q;
  assign serial_out_oe_n = so_oe_n_q;

  // Sticky frame events; a new event beats a same-cycle clear
  logic [2:0]  st_q;
  logic [23:0] last_q;
  logic        wr_go;
  logic [7:0]  wr_addr_q;
  logic [31:0] wr_data_q;
  logic [3:0]  wr_strb_q;
  logic        st_clr_en;
  assign st_clr_en = wr_go & (wr_addr_q == odsc_pkg::ADDR_STATUS) & wr_strb_q[0];
  always_ff @(posedge clk or posedge rst_all) begin
    if (rst_all) begin
      st_q   <= '0;
      last_q <= '0;
    end else begin
      st_q <= (st_q & ~(st_clr_en ? wr_data_q[2:0] : 3'h0)) | {reject_ev, abort_ev, commit};
      if (commit) last_q <= shift_q;
    end
  end

  // AXI write path: address and data taken independently, answered together
  logic awready_q, wready_q, bvalid_q;
  logic [1:0] bresp_q;
  logic wr_hit;
  assign wr_go  = ~awready_q & ~wready_q & ~bvalid_q;
  assign wr_hit = (wr_addr_q == odsc_pkg::ADDR_CTRL) | (wr_addr_q == odsc_pkg::ADDR_STATUS);
  always_ff @(posedge clk or posedge rst_all) begin
    if (rst_all) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= odsc_pkg::RESP_OKAY;
      wr_addr_q <= '0;
      wr_data_q <= '0;
      wr_strb_q <= '0;
    end else begin
      if (s_axi_awvalid & awready_q) begin
        awready_q <= 1'b0;
        wr_addr_q <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid & wready_q) begin
        wready_q  <= 1'b0;
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? odsc_pkg::RESP_OKAY : odsc_pkg::RESP_SLVERR;
      end
      if (bvalid_q & s_axi_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // Control register: bit 0 enables commits
  always_ff @(posedge clk or posedge rst_all) begin
    if (rst_all) begin
      ctrl_q <= odsc_pkg::CTRL_RST;
    end else if (wr_go & (wr_addr_q == odsc_pkg::ADDR_CTRL)) begin
      for (int b = 0; b < 4; b++) begin
        if (wr_strb_q[b]) ctrl_q[b*8 +: 8] <= wr_data_q[b*8 +: 8];
      end
    end
  end

  // AXI read path: answer in the cycle after the address is taken
  logic        arready_q, rvalid_q;
  logic [31:0] rdata_q, rd_mux;
  logic [1:0]  rresp_q;
  logic        rd_hit;
  always_comb begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    if (s_axi_araddr[7:5] == odsc_pkg::PAGE_DAC) begin
      rd_mux[DATA_W-1:0] = dac_q[s_axi_araddr[4:2]];
      rd_mux[DATA_W]     = pd_q[s_axi_araddr[4:2]];
      rd_mux[DATA_W+2 -: 2] = pdm_q[s_axi_araddr[4:2]];
    end else if (s_axi_araddr[7:5] == odsc_pkg::PAGE_BUF) begin
      rd_mux[DATA_W-1:0] = buf_q[s_axi_araddr[4:2]];
    end else begin
      case ({s_axi_araddr[7:2], 2'h0})
        odsc_pkg::ADDR_CTRL:   rd_mux = ctrl_q;
        odsc_pkg::ADDR_STATUS: begin
          rd_mux[2:0]                                 = st_q;
          rd_mux[odsc_pkg::ST_PD_LO +: NUM_CH]        = pd_q;
          rd_mux[odsc_pkg::ST_SLEEP]                  = ~sleep_s;
          rd_mux[odsc_pkg::ST_CHAIN]                  = chain_s;
          rd_mux[odsc_pkg::ST_FMT]                    = fmt_s;
        end
        odsc_pkg::ADDR_LAST:   rd_mux[23:0] = last_q;
        default:               rd_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst_all) begin
    if (rst_all) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= odsc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_arvalid & arready_q) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_mux;
        rresp_q   <= rd_hit ? odsc_pkg::RESP_OKAY : odsc_pkg::RESP_SLVERR;
      end else if (rvalid_q & s_axi_rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Checks on the frame path and the output stage
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst_all);

  sequence s_bit_in;
    shift_en & ~chain_s;
  endsequence
  sequence s_chain_bit;
    shift_en & chain_s;
  endsequence

  frame_count_a: assert property (cnt_q <= odsc_pkg::FRAME_LAST)
    else $error("bit count past frame length");
  msb_first_a: assert property (s_bit_in |=> shift_q[0] == $past(serial_in_s)
    && shift_q[23:1] == $past(shift_q[22:0])) else $error("shift order wrong");
  bad_prefix_a: assert property (sync_rise && state_q == odsc_pkg::ODSC_FULL
    && prefix != odsc_pkg::PREFIX_OK |=> $stable(dac_q) && $stable(buf_q)) else $error("bad prefix acted on");
  past_full_a: assert property (~chain_s && full && sclk_fall && ~sync_s |=> $stable(shift_q))
    else $error("bit taken after frame end");
  abort_keep_a: assert property (abort_ev |=> $stable(buf_q) && $stable(dac_q) && $stable(pd_q))
    else $error("aborted frame changed registers");
  single_load_a: assert property (commit && !pd_bit && ld == odsc_pkg::LD_BUF_DAC
    |=> dac_q[$past(pick)] == $past(data) && buf_q[$past(pick)] == $past(data)) else $error("load to DAC missed");
  group_pd_a: assert property (commit && pd_bit && ld[0] && pick == 3'h7
    |=> pd_q == {NUM_CH{1'b1}} && pdm_q[7] == $past(pdm)) else $error("group power-down missed");
  sleep_hiz_a: assert property (~sleep_s |=> ch_power_down == {NUM_CH{1'b1}}
    && ch_pd_mode == '0 && $stable(pd_q)) else $error("sleep not applied");
  // Checks the chain shift itself, not only the output register copy
  chain_out_a: assert property (s_chain_bit |=> shift_q == {$past(shift_q[22:0]), $past(serial_in_s)}
    ##1 serial_out == $past(shift_q[23])) else $error("chain shift or output wrong");
  out_hiz_a: assert property (sync_s || ~chain_s |=> serial_out_oe_n)
    else $error("serial out driven outside chain frame");
  fmt_flip_a: assert property (##1 $stable(dac_q) && $stable(fmt_s) |-> dac_code[11:0] == (dac_q[0] ^ {fmt_s, 11'h0}))
    else $error("format mapping wrong");

endmodule

//--- verif/odsc_host_model.sv
// Host serial port model: frames words onto the three-wire link.
// Assumes the device oversamples the link with its own faster clock.
`timescale 1ns/1ps
module odsc_host_model (
  output logic        frame_sync_n,
  output logic        serial_clk,
  output logic        serial_in,
  input  wire logic   serial_out,
  output logic [47:0] so_cap
);
  // Idle link: sync high, clock parked high
  initial begin
    frame_sync_n = 1'b1;
    serial_clk   = 1'b1;
    serial_in    = 1'b0;
    so_cap       = 48'h0;
  end
  // MSB first, data moves while the clock is high, 125 ns period
  task automatic send(input logic [47:0] w, input int n, input bit chain);
    // Start off the system clock edge so the sampling order is fixed
    #2 frame_sync_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = w[i];
      #62.5 serial_clk = 1'b0;
      #62.5 serial_clk = 1'b1;
      so_cap = {so_cap[46:0], serial_out};
    end
    serial_in = ~serial_in;  // Released line shows no stale bit
    #62.5 frame_sync_n = 1'b1;
    // Chained parts need one more fall to re-arm
    if (chain) begin
      #62.5 serial_clk = 1'b0;
      #62.5 serial_clk = 1'b1;
    end
    #200;
  endtask
endmodule

//--- verif/tb_octal_dac_serial_control.sv
// Self-checking bench for the octal DAC serial control block.
// Assumes odsc_pkg, odsc_top and the host model are compiled first.
`timescale 1ns/1ps
module tb_octal_dac_serial_control;
  logic        clk, sys_rst, chain_enable, sleep_pin_n, clear_n, reset_level_select;
  logic        frame_sync_n, serial_clk, serial_in, serial_out, serial_out_oe_n;
  logic [95:0] dac_code;
  logic [7:0]  ch_power_down, s_axi_awaddr, s_axi_araddr;
  logic [15:0] ch_pd_mode;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [47:0] so_cap, w;
  logic [11:0] e [8];
  logic [11:0] t;
  int          n_errors, checks, cycles, seed;

  odsc_top dut (.clk, .sys_rst, .frame_sync_n, .serial_clk, .serial_in, .chain_enable, .sleep_pin_n, .clear_n,
    .reset_level_select, .serial_out, .serial_out_oe_n, .dac_code, .ch_power_down, .ch_pd_mode,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  odsc_host_model host (.frame_sync_n, .serial_clk, .serial_in, .serial_out, .so_cap);

  // 100 MHz system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard, well above the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (n_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic chall();
    for (int c = 0; c < 8; c++) chk(dac_code[c*12 +: 12], e[c]);
  endtask
  // Code the output stage should show for a raw word in a given format
  function automatic logic [11:0] obin(input logic [11:0] d, input logic f);
    return d ^ {f, 11'h0};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Frame, then room for the synchronisers and commit
  task automatic snd(input logic [47:0] x, input int n);
    host.send(x, n, chain_enable);
    cyc(10);
  endtask
  task automatic frm(input logic [1:0] l, input logic [2:0] p, input logic pd, input logic [11:0] d);
    snd({24'h0, 2'b00, l, p, pd, d, 4'h0}, 24);
  endtask
  // Each valid drops only at its own handshake edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Main sequence
  initial begin
    seed = 32'h7deb;
    {sys_rst, clear_n, sleep_pin_n, reset_level_select, chain_enable} = 5'h1c;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    foreach (e[i]) e[i] = 12'h0;
    cyc(2);
    sys_rst <= 1'b0;
    cyc(6);
    chall();
    for (int c = 0; c < 8; c++) begin
      e[c] = $random(seed);
      frm(2'h1, c[2:0], 1'b0, e[c]);
    end
    chall();
    // Bad prefix, then a frame cut one bit short
    snd({24'h0, 8'h90, ~e[0], 4'h0}, 24);
    snd({24'h0, 8'h10, ~e[0], 4'h0}, 23);
    chall();
    axr(8'h04, rd, rr);
    chk(rd[2:0], 3'h7);
    e[2] = $random(seed);
    snd({18'h0, 8'h14, e[2], 4'h0, 6'h2a}, 30);
    chall();
    axr(8'h08, rd, rr);
    chk(rd[23:0], {8'h14, e[2], 4'h0});
    axw(8'h04, 32'h7, rr);
    axr(8'h04, rd, rr);
    chk({rd[2:0], rr}, 5'h0);
    // Commits switched off: a good frame is only flagged as rejected
    axw(8'h00, 32'h0, rr);
    frm(2'h1, 3'h0, 1'b0, ~e[0]);
    axw(8'h00, 32'h1, rr);
    chall();
    axr(8'h04, rd, rr);
    chk(rd[2:0], 3'h4);
    axr(8'h00, rd, rr);
    chk({rd, rr}, 34'h4);
    axw(8'hfc, 32'h0, rr);
    chk(rr, 2'h2);
    axr(8'hfc, rd, rr);
    chk({rd, rr}, 34'h2);
    // Buffer-only write stays hidden until a load pulls it through
    t = $random(seed);
    frm(2'h0, 3'h1, 1'b0, t);
    chall();
    e[1] = t;
    e[0] = $random(seed);
    frm(2'h2, 3'h0, 1'b0, e[0]);
    chall();
    e[0] = $random(seed);
    e[1] = e[0];
    frm(2'h3, 3'h4, 1'b0, e[0]);
    e[3] = $random(seed);
    frm(2'h0, 3'h3, 1'b0, e[3]);
    frm(2'h3, 3'h1, 1'b0, 12'h0);
    chall();
    for (int m = 0; m < 4; m++) begin
      frm(2'h0, m[2:0], 1'b1, {4'h0, m[1:0], 6'h0});
      chk({ch_power_down[m], ch_pd_mode[2*m +: 2]}, {1'b1, m[1:0]});
    end
    frm(2'h1, 3'h5, 1'b1, 12'h080);
    chk({ch_power_down, ch_pd_mode}, {8'h7f, 16'h2aaa});
    sleep_pin_n <= 1'b0;
    cyc(6);
    chk({ch_power_down, ch_pd_mode}, {8'hff, 16'h0});
    sleep_pin_n <= 1'b1;
    cyc(6);
    chk({ch_power_down, ch_pd_mode}, {8'h7f, 16'h2aaa});
    // Top group code reaches every channel
    frm(2'h1, 3'h7, 1'b1, 12'h040);
    chk({ch_power_down, ch_pd_mode}, {8'hff, 16'h5555});
    clear_n <= 1'b0;
    cyc(2);
    foreach (e[i]) e[i] = 12'h0;
    chall();
    chk(ch_power_down, 8'h0);
    clear_n <= 1'b1;
    cyc(6);
    e[5] = $random(seed);
    frm(2'h1, 3'h5, 1'b0, e[5]);
    chall();
    {reset_level_select, sys_rst} <= 2'h3;
    cyc(2);
    sys_rst <= 1'b0;
    cyc(6);
    foreach (e[i]) e[i] = 12'h800;
    chall();
    t = $random(seed);
    frm(2'h1, 3'h6, 1'b0, t);
    e[6] = obin(t, 1'b1);
    chall();
    // Chain: first word must reappear 24 clocks later
    chain_enable <= 1'b1;
    cyc(6);
    w[47:24] = $random(seed);
    t = $random(seed);
    snd({w[47:24], 8'h1e, t, 4'h0}, 48);
    e[7] = obin(t, 1'b1);
    chk(so_cap[24:1], w[47:24]);
    chall();
    chk(serial_out_oe_n, 1'b1);
    end_sim();
  end
endmodule
